/* File: pch_pkg.sv */
// Shared constants and types of the position command handler
`default_nettype none
package pch_pkg;
    // ************************************************************
    // Object addressing and service codes
    // ************************************************************
    localparam logic [15:0] PCH_CLASS_CODE = 16'h0023;
    localparam logic [15:0] PCH_CLASS_INST = 16'h0000;
    localparam logic [7:0] SVC_RESET = 8'h05;
    localparam logic [7:0] SVC_GET = 8'h0e;
    localparam logic [7:0] SVC_SET = 8'h10;
    localparam logic [7:0] SVC_RESTORE = 8'h15;
    localparam logic [7:0] SVC_SAVE = 8'h16;
    localparam logic [7:0] SVC_DEV_RESET = 8'h4b;
    // ************************************************************
    // Attribute identifiers
    // ************************************************************
    localparam logic [7:0] ATTR_NONE = 8'h00;
    localparam logic [7:0] ATTR_CLASS_REV = 8'h01;
    localparam logic [7:0] ATTR_POS = 8'h0a;
    localparam logic [7:0] ATTR_TYPE = 8'h0b;
    localparam logic [7:0] ATTR_DIR = 8'h0c;
    localparam logic [7:0] ATTR_SCALE = 8'h0e;
    localparam logic [7:0] ATTR_CPT = 8'h10;
    localparam logic [7:0] ATTR_TMR = 8'h11;
    localparam logic [7:0] ATTR_PRESET = 8'h13;
    localparam logic [7:0] ATTR_VELFMT = 8'h19;
    localparam logic [7:0] ATTR_OFFSET = 8'h33;
    localparam logic [31:0] CLASS_REVISION = 32'h0000_0002;
    localparam logic [31:0] TYPE_SINGLE = 32'h0000_0001;
    localparam logic [31:0] TYPE_MULTI = 32'h0000_0002;
    // ************************************************************
    // Response status codes
    // ************************************************************
    localparam logic [7:0] STS_OK = 8'h00;
    localparam logic [7:0] STS_BAD_PATH = 8'h05;
    localparam logic [7:0] STS_BAD_SVC = 8'h08;
    localparam logic [7:0] STS_BAD_VALUE = 8'h09;
    localparam logic [7:0] STS_NOT_ENOUGH = 8'h13;
    localparam logic [7:0] STS_BAD_ATTR = 8'h14;
    localparam logic [7:0] STS_TOO_MUCH = 8'h15;
    // ************************************************************
    // Data lengths and ranges
    // ************************************************************
    localparam logic [2:0] LEN_NONE = 3'h0;
    localparam logic [2:0] LEN_BYTE = 3'h1;
    localparam logic [2:0] LEN_WORD = 3'h2;
    localparam logic [2:0] LEN_DWORD = 3'h4;
    localparam logic [31:0] RANGE_SINGLE = 32'h0001_0000;
    localparam logic [31:0] RANGE_MULTI = 32'h4000_0000;
    localparam logic [31:0] CPT_MIN = 32'h0000_0001;
    localparam logic [31:0] CPT_MAX = 32'h0001_0000;
    localparam logic [31:0] TMR_MIN = 32'h0000_0002;
    // ************************************************************
    // Parameter image, same layout in working and stored copies
    // ************************************************************
    typedef struct packed {
        logic dir;
        logic scale;
        logic [16:0] cpt;
        logic [30:0] tmr;
        logic [15:0] velfmt;
        logic [31:0] offset;
    } pch_image_t;
    localparam pch_image_t PCH_DEFAULT_IMG = '{dir: 1'b0, scale: 1'b0, cpt: 17'h1_0000,
        tmr: 31'h0, velfmt: 16'h1f04, offset: 32'h0};
    typedef enum logic [1:0] {OP_NONE, OP_SET, OP_DEFAULTS, OP_LOAD} pch_op_t;
    typedef enum logic [3:0] {
        S_BOOT = 4'h1,
        S_IDLE = 4'h2,
        S_EXEC = 4'h4,
        S_RESP = 4'h8
    } pch_state_t;
endpackage
`default_nettype wire

/* File: pch_param_if.sv */
// Link between the command decoder and the parameter store
`default_nettype none
interface pch_param_if;
    import pch_pkg::*;
    pch_op_t op;
    logic [7:0] attr;
    logic [31:0] wdata;
    pch_image_t load_img;
    pch_image_t img;
    modport ctrl (output op, output attr, output wdata, output load_img, input img);
    modport store (input op, input attr, input wdata, input load_img, output img);
endinterface
`default_nettype wire

/* File: pch_param_store.sv */
// Working parameter store of the position command handler
`default_nettype none
module pch_param_store
    import pch_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    pch_param_if.store pif
);
    pch_image_t img_ff;
    pch_image_t nxt_img;

    // ************************************************************
    // Update of the working copy
    // ************************************************************
    always_comb begin
        nxt_img = img_ff;
        case (pif.op)
            OP_SET: begin
                case (pif.attr)
                    ATTR_DIR: nxt_img.dir = pif.wdata[0];
                    ATTR_SCALE: nxt_img.scale = pif.wdata[0];
                    ATTR_CPT: nxt_img.cpt = pif.wdata[16:0];
                    ATTR_TMR: nxt_img.tmr = pif.wdata[30:0];
                    ATTR_VELFMT: nxt_img.velfmt = pif.wdata[15:0];
                    ATTR_PRESET: nxt_img.offset = pif.wdata; // [RQ1] [RQ17]
                    default: nxt_img = img_ff;
                endcase
            end
            // Network settings live elsewhere and are untouched here
            OP_DEFAULTS: nxt_img = PCH_DEFAULT_IMG; // [RQ7] [RQ8] [RQ10]
            OP_LOAD: nxt_img = pif.load_img; // [RQ6] [RQ9] [RQ13]
            default: nxt_img = img_ff;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            img_ff <= PCH_DEFAULT_IMG;
        end else begin
            img_ff <= nxt_img;
        end
    end

    assign pif.img = img_ff;

    AST_DEFAULTS_LOAD: assert property (@(posedge clk) disable iff (!rst_b) // [RQ7]
        (pif.op == OP_DEFAULTS) |=> (img_ff == PCH_DEFAULT_IMG))
        else $error("Factory defaults were not applied");
endmodule
`default_nettype wire

/* File: pch_handler.sv */
// Explicit message handler of the position sensor object
// Operation
// RQ1 - A preset changes only the working offset, not stored copy.
// RQ2 - Controller sends four preset bytes, least significant first.
// RQ3 - Preset from zero to full scale makes position equal it.
// RQ4 - Preset range follows variant, scaling enable and total range.
// RQ5 - Save carries no data and stores parameters and offset.
// RQ6 - Restore carries no data and reloads last stored parameters.
// RQ7 - Factory default needs no data, attribute zero; loads defaults.
// RQ8 - Factory default keeps network address, mask and gateway.
// RQ9 - Device reset needs no data, attribute zero; resets and reloads.
// RQ10 - Service 16#05 only at class level, restores factory defaults.
// RQ11 - Service 16#0E at class and instance level, reads attribute.
// RQ12 - Service 16#10 only at instance level, writes attribute.
// RQ13 - Service 16#15 only at class level, reloads stored parameters.
// RQ14 - Service 16#16 only at class level, stores parameters and offset.
// RQ15 - Controller addresses instance zero for class-level services.
// RQ16 - Class attribute 1 alone exists and always reads revision 2.
// RQ17 - Preset attribute write computes offset, kept only after save.
// RQ18 - Controller uses class code 16#23 for sensor instances.
// RQ19 - Unimplemented service at addressed level answers error, no change.
`default_nettype none
module pch_handler
    import pch_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic multi_turn_pin,
    input wire logic [31:0] sensor_pos,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_service,
    input wire logic [15:0] cmd_class,
    input wire logic [15:0] cmd_instance,
    input wire logic [7:0] cmd_attr,
    input wire logic [2:0] cmd_len,
    input wire logic [31:0] cmd_data,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_status,
    output logic [31:0] rsp_data,
    output logic [31:0] position,
    input wire pch_image_t nv_rd_data,
    output logic nv_wr_en,
    output pch_image_t nv_wr_data,
    output logic dev_reset_req
);
    pch_param_if pif();

    pch_param_store u_store (
        .clk(clk),
        .rst_b(rst_b),
        .pif(pif)
    );

    pch_state_t state_ff, nxt_state;
    logic mt_s1_ff, mt_s2_ff;
    logic [7:0] svc_ff, nxt_svc, attr_ff, nxt_attr;
    logic [15:0] class_ff, nxt_class, inst_ff, nxt_inst;
    logic [2:0] len_ff, nxt_len;
    logic [31:0] data_ff, nxt_data;
    logic ready_ff, nxt_ready, rsp_valid_ff, nxt_rsp_valid;
    logic [7:0] rsp_status_ff, nxt_rsp_status;
    logic [31:0] rsp_data_ff, nxt_rsp_data, position_ff, nxt_position;
    logic nv_wr_en_ff, nxt_nv_wr_en, dev_reset_ff, nxt_dev_reset;
    pch_image_t nv_wr_data_ff, nxt_nv_wr_data;
    logic [31:0] limit, eraw, pos_sum, preset_offset, native_range, tmr_ext, cpt_ext;
    logic [7:0] sts;
    logic [31:0] rdata;
    logic [2:0] need_len;
    logic is_class, save_hit, devrst_hit;
    pch_op_t op;

    // ************************************************************
    // Variant strap synchroniser
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mt_s1_ff <= 1'b0;
            mt_s2_ff <= 1'b0;
        end else begin
            mt_s1_ff <= multi_turn_pin;
            mt_s2_ff <= mt_s1_ff;
        end
    end

    // ************************************************************
    // Range, offset and position arithmetic
    // ************************************************************
    // Sensor reading is assumed already reduced below the active range
    always_comb begin
        tmr_ext = {1'b0, pif.img.tmr};
        cpt_ext = {15'h0, pif.img.cpt};
        native_range = mt_s2_ff ? RANGE_MULTI : RANGE_SINGLE;
        if (tmr_ext != 32'h0) begin
            limit = tmr_ext; // [RQ4]
        end else if (pif.img.scale) begin
            limit = cpt_ext; // [RQ4]
        end else begin
            limit = native_range; // [RQ4]
        end
        if (pif.img.dir && sensor_pos != 32'h0) begin
            eraw = limit - sensor_pos;
        end else begin
            eraw = sensor_pos;
        end
        if (data_ff >= eraw) begin
            preset_offset = data_ff - eraw; // [RQ3] [RQ17]
        end else begin
            preset_offset = data_ff + (limit - eraw); // [RQ3] [RQ17]
        end
        pos_sum = eraw + pif.img.offset;
        if (pos_sum >= limit) begin
            nxt_position = pos_sum - limit;
        end else begin
            nxt_position = pos_sum;
        end
    end

    // ************************************************************
    // Service decode
    // ************************************************************
    always_comb begin
        sts = STS_OK;
        rdata = 32'h0;
        op = OP_NONE;
        save_hit = 1'b0;
        devrst_hit = 1'b0;
        need_len = LEN_NONE;
        is_class = (inst_ff == PCH_CLASS_INST); // [RQ15]
        case (attr_ff)
            ATTR_DIR: need_len = LEN_BYTE;
            ATTR_SCALE: need_len = LEN_BYTE;
            ATTR_VELFMT: need_len = LEN_WORD;
            default: need_len = LEN_DWORD; // [RQ2]
        endcase
        if (class_ff != PCH_CLASS_CODE) begin
            sts = STS_BAD_PATH; // [RQ18]
        end else begin
            case (svc_ff)
                SVC_RESET, SVC_RESTORE, SVC_SAVE, SVC_DEV_RESET: begin
                    if (!is_class) begin
                        sts = STS_BAD_SVC; // [RQ10] [RQ13] [RQ14] [RQ19]
                    end else if (len_ff != LEN_NONE) begin
                        sts = STS_TOO_MUCH; // [RQ5] [RQ6] [RQ7] [RQ9]
                    end else if ((svc_ff == SVC_RESET || svc_ff == SVC_DEV_RESET)
                            && attr_ff != ATTR_NONE) begin
                        sts = STS_BAD_ATTR; // [RQ7] [RQ9]
                    end else if (svc_ff == SVC_RESET) begin
                        op = OP_DEFAULTS; // [RQ10]
                    end else if (svc_ff == SVC_RESTORE) begin
                        op = OP_LOAD; // [RQ13]
                    end else if (svc_ff == SVC_SAVE) begin
                        save_hit = 1'b1; // [RQ14]
                    end else begin
                        op = OP_LOAD; // [RQ9]
                        devrst_hit = 1'b1; // [RQ9]
                    end
                end
                SVC_GET: begin
                    if (len_ff != LEN_NONE) begin
                        sts = STS_TOO_MUCH;
                    end else if (is_class) begin
                        if (attr_ff == ATTR_CLASS_REV) begin
                            rdata = CLASS_REVISION; // [RQ16]
                        end else begin
                            sts = STS_BAD_ATTR; // [RQ16]
                        end
                    end else begin
                        case (attr_ff) // [RQ11]
                            ATTR_POS: rdata = position_ff;
                            ATTR_TYPE: rdata = mt_s2_ff ? TYPE_MULTI : TYPE_SINGLE;
                            ATTR_DIR: rdata = {31'h0, pif.img.dir};
                            ATTR_SCALE: rdata = {31'h0, pif.img.scale};
                            ATTR_CPT: rdata = cpt_ext;
                            ATTR_TMR: rdata = tmr_ext;
                            ATTR_VELFMT: rdata = {16'h0, pif.img.velfmt};
                            ATTR_OFFSET: rdata = pif.img.offset;
                            default: sts = STS_BAD_ATTR;
                        endcase
                    end
                end
                SVC_SET: begin
                    if (is_class) begin
                        sts = STS_BAD_SVC; // [RQ12] [RQ19]
                    end else if (!(attr_ff == ATTR_DIR || attr_ff == ATTR_SCALE
                            || attr_ff == ATTR_CPT || attr_ff == ATTR_TMR
                            || attr_ff == ATTR_PRESET || attr_ff == ATTR_VELFMT)) begin
                        sts = STS_BAD_ATTR;
                    end else if (len_ff < need_len) begin
                        sts = STS_NOT_ENOUGH; // [RQ2]
                    end else if (len_ff > need_len) begin
                        sts = STS_TOO_MUCH; // [RQ2]
                    end else if (attr_ff == ATTR_PRESET && data_ff >= limit) begin
                        sts = STS_BAD_VALUE; // [RQ3] [RQ4]
                    end else if (attr_ff == ATTR_CPT
                            && (data_ff < CPT_MIN || data_ff > CPT_MAX)) begin
                        sts = STS_BAD_VALUE;
                    end else if (attr_ff == ATTR_TMR && (data_ff > native_range
                            || (data_ff != 32'h0 && data_ff < TMR_MIN))) begin
                        sts = STS_BAD_VALUE;
                    end else begin
                        op = OP_SET; // [RQ12]
                    end
                end
                default: sts = STS_BAD_SVC; // [RQ19]
            endcase
        end
    end

    assign pif.op = (state_ff == S_BOOT) ? OP_LOAD : ((state_ff == S_EXEC) ? op : OP_NONE);
    assign pif.attr = attr_ff;
    assign pif.wdata = (attr_ff == ATTR_PRESET) ? preset_offset : data_ff; // [RQ1]
    assign pif.load_img = nv_rd_data;

    // ************************************************************
    // Command sequencing
    // ************************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_svc = svc_ff;
        nxt_attr = attr_ff;
        nxt_class = class_ff;
        nxt_inst = inst_ff;
        nxt_len = len_ff;
        nxt_data = data_ff;
        nxt_rsp_valid = 1'b0;
        nxt_rsp_status = rsp_status_ff;
        nxt_rsp_data = rsp_data_ff;
        nxt_nv_wr_en = 1'b0;
        nxt_nv_wr_data = nv_wr_data_ff;
        nxt_dev_reset = 1'b0;
        case (state_ff)
            S_BOOT: nxt_state = S_IDLE;
            S_IDLE: begin
                if (cmd_valid && ready_ff) begin
                    nxt_svc = cmd_service;
                    nxt_attr = cmd_attr;
                    nxt_class = cmd_class;
                    nxt_inst = cmd_instance;
                    nxt_len = cmd_len;
                    nxt_data = cmd_data; // [RQ2]
                    nxt_state = S_EXEC;
                end
            end
            S_EXEC: begin
                nxt_rsp_valid = 1'b1;
                nxt_rsp_status = sts;
                nxt_rsp_data = rdata;
                if (save_hit) begin
                    nxt_nv_wr_en = 1'b1; // [RQ5] [RQ14]
                    nxt_nv_wr_data = pif.img; // [RQ5] [RQ14]
                end
                nxt_dev_reset = devrst_hit; // [RQ9]
                nxt_state = S_RESP;
            end
            S_RESP: nxt_state = S_IDLE;
            default: nxt_state = S_IDLE;
        endcase
        nxt_ready = (nxt_state == S_IDLE);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff <= S_BOOT;
            svc_ff <= 8'h0;
            attr_ff <= 8'h0;
            class_ff <= 16'h0;
            inst_ff <= 16'h0;
            len_ff <= 3'h0;
            data_ff <= 32'h0;
            ready_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_status_ff <= STS_OK;
            rsp_data_ff <= 32'h0;
            position_ff <= 32'h0;
            nv_wr_en_ff <= 1'b0;
            nv_wr_data_ff <= PCH_DEFAULT_IMG;
            dev_reset_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            svc_ff <= nxt_svc;
            attr_ff <= nxt_attr;
            class_ff <= nxt_class;
            inst_ff <= nxt_inst;
            len_ff <= nxt_len;
            data_ff <= nxt_data;
            ready_ff <= nxt_ready;
            rsp_valid_ff <= nxt_rsp_valid;
            rsp_status_ff <= nxt_rsp_status;
            rsp_data_ff <= nxt_rsp_data;
            position_ff <= nxt_position;
            nv_wr_en_ff <= nxt_nv_wr_en;
            nv_wr_data_ff <= nxt_nv_wr_data;
            dev_reset_ff <= nxt_dev_reset;
        end
    end

    assign cmd_ready = ready_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_status = rsp_status_ff;
    assign rsp_data = rsp_data_ff;
    assign position = position_ff;
    assign nv_wr_en = nv_wr_en_ff;
    assign nv_wr_data = nv_wr_data_ff;
    assign dev_reset_req = dev_reset_ff;

    // ************************************************************
    // Checks
    // ************************************************************
    AST_PRESET_POS: assert property (@(posedge clk) disable iff (!rst_b) // [RQ3]
        (state_ff == S_EXEC && op == OP_SET && attr_ff == ATTR_PRESET)
        ##1 $stable(sensor_pos) |-> ##1 (position_ff == $past(data_ff, 2)))
        else $error("Position differs from applied preset");
    AST_PRESET_VOLATILE: assert property (@(posedge clk) disable iff (!rst_b) // [RQ1]
        (state_ff == S_EXEC && op == OP_SET) |=> !nv_wr_en_ff [*2])
        else $error("Preset reached stored copy without save");
    AST_PRESET_RANGE: assert property (@(posedge clk) disable iff (!rst_b) // [RQ4]
        (state_ff == S_EXEC && svc_ff == SVC_SET && attr_ff == ATTR_PRESET
        && class_ff == PCH_CLASS_CODE && !is_class && len_ff == LEN_DWORD
        && data_ff >= limit) |=> (rsp_valid_ff && rsp_status_ff == STS_BAD_VALUE))
        else $error("Out of range preset accepted");
    AST_SAVE_IMAGE: assert property (@(posedge clk) disable iff (!rst_b) // [RQ14]
        (state_ff == S_EXEC && save_hit) |=> (nv_wr_en_ff && rsp_status_ff == STS_OK
        && nv_wr_data_ff == $past(pif.img)))
        else $error("Save did not store working parameters");
    AST_CLASS_ONLY: assert property (@(posedge clk) disable iff (!rst_b) // [RQ10]
        (state_ff == S_EXEC && class_ff == PCH_CLASS_CODE && !is_class
        && (svc_ff == SVC_RESET || svc_ff == SVC_RESTORE || svc_ff == SVC_SAVE))
        |=> (rsp_status_ff == STS_BAD_SVC && !nv_wr_en_ff))
        else $error("Class level service accepted at instance");
    AST_SET_INSTANCE: assert property (@(posedge clk) disable iff (!rst_b) // [RQ12]
        (state_ff == S_EXEC && svc_ff == SVC_SET && class_ff == PCH_CLASS_CODE
        && is_class) |=> (rsp_status_ff == STS_BAD_SVC))
        else $error("Set service accepted at class level");
    AST_CLASS_REV: assert property (@(posedge clk) disable iff (!rst_b) // [RQ16]
        (state_ff == S_EXEC && svc_ff == SVC_GET && class_ff == PCH_CLASS_CODE
        && is_class && attr_ff == ATTR_CLASS_REV && len_ff == LEN_NONE)
        |=> (rsp_data_ff == CLASS_REVISION && rsp_status_ff == STS_OK))
        else $error("Class revision read wrong");
    AST_REJECT_HOLD: assert property (@(posedge clk) disable iff (!rst_b) // [RQ19]
        (state_ff == S_EXEC && sts != STS_OK) |=> ($stable(pif.img) && !nv_wr_en_ff)
        ##1 $stable(pif.img))
        else $error("Rejected service changed parameters");
    AST_DEV_RESET: assert property (@(posedge clk) disable iff (!rst_b) // [RQ9]
        (state_ff == S_EXEC && devrst_hit) |=> (dev_reset_ff && pif.img == $past(nv_rd_data))
        ##1 !dev_reset_ff)
        else $error("Device reset did not pulse and reload");
endmodule
`default_nettype wire

/* File: pch_nv_model.sv */
// Nonvolatile parameter memory seen by the position command handler
`default_nettype none
module pch_nv_model
    import pch_pkg::*;
(
    input wire logic clk,
    input wire logic nv_wr_en,
    input wire pch_image_t nv_wr_data,
    output var pch_image_t nv_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    pch_image_t mem = PCH_DEFAULT_IMG;
    // Stored copy is presented combinationally, as the handler expects
    assign nv_rd_data = mem;
    always @(posedge clk) begin
        if (nv_wr_en === 1'b1) begin
            mem <= nv_wr_data;
        end
    end
endmodule
`default_nettype wire

/* File: pch_tb_top.sv */
// Self-checking testbench of the position command handler
`default_nettype none
module pch_tb_top
    import pch_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, mt, cv, rdy, rv, nvw, drq, c_drq, c_nvw;
    logic [7:0] svc, attr, stat, st;
    logic [15:0] inst;
    logic [2:0] len;
    logic [31:0] sens, dat, rdata, rd, pos, lf, p1, p2;
    pch_image_t nvr, nvd;
    int mismatches, compares, lat;
    logic [15:0] cls;
    logic [7:0] svc_bad [5] = '{SVC_SAVE, SVC_RESTORE, SVC_RESET, SVC_SET, 8'h33};
    logic [15:0] inst_bad [5] = '{16'h1, 16'h1, 16'h1, 16'h0, 16'h1};
    pch_handler u_pch_handler (.clk(clk), .rst_b(rst_b), .multi_turn_pin(mt),
        .sensor_pos(sens), .cmd_valid(cv), .cmd_service(svc), .cmd_class(cls),
        .cmd_instance(inst), .cmd_attr(attr), .cmd_len(len), .cmd_data(dat),
        .cmd_ready(rdy), .rsp_valid(rv), .rsp_status(stat), .rsp_data(rdata),
        .position(pos), .nv_rd_data(nvr), .nv_wr_en(nvw), .nv_wr_data(nvd),
        .dev_reset_req(drq));
    pch_nv_model u_pch_nv_model (.clk(clk), .nv_wr_en(nvw), .nv_wr_data(nvd),
        .nv_rd_data(nvr));
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk8(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: status %h expected %h", $time, g, e);
        end
    endtask
    task chk32(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: word %h expected %h", $time, g, e);
        end
    endtask
    task chk1(input logic g, input logic e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: flag %b expected %b", $time, g, e);
        end
    endtask
    task end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Present one command, hold it until taken, then capture the answer
    task cmd(input logic [7:0] s, input logic [15:0] i, input logic [7:0] a,
        input logic [2:0] l, input logic [31:0] d);
        int n;
        @(posedge clk);
        cv <= 1'b1;
        svc <= s;
        inst <= i;
        attr <= a;
        len <= l;
        dat <= d;
        n = 0;
        #1;
        while (rdy !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        cv <= 1'b0;
        lat = 0;
        do begin
            @(posedge clk);
            #1;
            lat++;
        end while (rv !== 1'b1 && lat < 10);
        if (n >= 20 || lat >= 10) begin
            mismatches++;
            $display("wrong value at %0t: no answer", $time);
            end_sim;
        end else begin
            st = stat;
            rd = rdata;
            c_drq = drq;
            c_nvw = nvw;
            // Answer stands one edge after the edge that took the command
            chk8(8'(lat), 8'h01);
        end
    endtask
    task pos_chk(input logic [31:0] e);
        repeat (2) @(posedge clk);
        #1;
        chk32(pos, e);
    endtask
    // ************************************************************
    // Clock, watchdog and main sequence
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("wrong value at %0t: run too long", $time);
        end_sim;
    end
    initial begin
        {rst_b, mt, cv, svc, inst, attr, len, dat} = '0;
        cls = PCH_CLASS_CODE;
        mismatches = 0;
        compares = 0;
        lf = lfsr(32'hf67925a7);
        sens = {17'h0, lf[14:0]};
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        cmd(SVC_GET, 16'h0, ATTR_CLASS_REV, LEN_NONE, 32'h0);
        chk32(rd, CLASS_REVISION);
        cmd(SVC_GET, 16'h0, ATTR_TYPE, LEN_NONE, 32'h0);
        chk8(st, STS_BAD_ATTR);
        $display("test class attribute done");
        lf = lfsr(lf);
        p1 = {16'h0, lf[15:0]};
        cmd(SVC_SET, 16'h1, ATTR_PRESET, LEN_DWORD, p1);
        chk8(st, STS_OK);
        chk1(c_nvw, 1'b0);
        pos_chk(p1);
        cmd(SVC_SAVE, 16'h0, ATTR_NONE, LEN_NONE, 32'h0);
        chk1(c_nvw, 1'b1);
        chk32(nvd.offset, {16'h0, p1[15:0] - sens[15:0]});
        p2 = 32'h0000ffff;
        cmd(SVC_SET, 16'h1, ATTR_PRESET, LEN_DWORD, p2);
        pos_chk(p2);
        cmd(SVC_SET, 16'h1, ATTR_PRESET, LEN_DWORD, 32'h00010000);
        chk8(st, STS_BAD_VALUE);
        cmd(SVC_SET, 16'h1, ATTR_PRESET, 3'h3, p1);
        chk8(st, STS_NOT_ENOUGH);
        pos_chk(p2);
        cmd(SVC_RESTORE, 16'h0, ATTR_NONE, LEN_NONE, 32'h0);
        pos_chk(p1);
        $display("test preset save restore done");
        foreach (svc_bad[k]) begin
            cmd(svc_bad[k], inst_bad[k], ATTR_PRESET, LEN_NONE, 32'h0);
            chk8(st, STS_BAD_SVC);
        end
        pos_chk(p1);
        cls <= 16'h0024;
        cmd(SVC_GET, 16'h1, ATTR_POS, LEN_NONE, 32'h0);
        chk8(st, STS_BAD_PATH);
        cls <= PCH_CLASS_CODE;
        $display("test wrong level done");
        cmd(SVC_RESET, 16'h0, ATTR_NONE, LEN_NONE, 32'h0);
        chk1(c_nvw, 1'b0);
        pos_chk(sens);
        cmd(SVC_DEV_RESET, 16'h0, ATTR_NONE, LEN_NONE, 32'h0);
        chk1(c_drq, 1'b1);
        pos_chk(p1);
        $display("test defaults and device reset done");
        mt <= 1'b1;
        cmd(SVC_GET, 16'h1, ATTR_TYPE, LEN_NONE, 32'h0);
        chk32(rd, TYPE_MULTI);
        cmd(SVC_SET, 16'h1, ATTR_PRESET, LEN_DWORD, 32'h3fffffff);
        pos_chk(32'h3fffffff);
        cmd(SVC_SET, 16'h1, ATTR_PRESET, LEN_DWORD, RANGE_MULTI);
        chk8(st, STS_BAD_VALUE);
        $display("test multi-turn range done");
        end_sim;
    end
endmodule
`default_nettype wire
